/* hdl/blfss_pkg.sv */
// package: constants, register map and types of the backlight fault sequencer
package blfss_pkg;

  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned NUM_STR = 4;
  // state durations in their own units
  localparam int unsigned SOFT_START_MS = 65;
  localparam int unsigned BOOST_START_MS = 50;
  localparam int unsigned RETRY_MS = 100;
  localparam int unsigned BOOST_OVP_MS = 560;
  localparam int unsigned EN_CLEAR_MIN_US = 2;
  localparam int unsigned EN_CLEAR_MAX_US = 20;
  localparam int unsigned EN_STANDBY_US = 50;
  localparam int unsigned SOFT_START_CYC = SOFT_START_MS * 1000 * CLK_MHZ;
  localparam int unsigned BOOST_START_CYC = BOOST_START_MS * 1000 * CLK_MHZ;
  localparam int unsigned RETRY_CYC = RETRY_MS * 1000 * CLK_MHZ;
  localparam int unsigned BOOST_OVP_CYC = BOOST_OVP_MS * 1000 * CLK_MHZ;
  localparam int unsigned EN_CLEAR_MIN_CYC = EN_CLEAR_MIN_US * CLK_MHZ;
  localparam int unsigned EN_CLEAR_MAX_CYC = EN_CLEAR_MAX_US * CLK_MHZ;
  localparam int unsigned EN_STANDBY_CYC = EN_STANDBY_US * CLK_MHZ;
  localparam int unsigned CNT_W = 32;

  // axi4-lite register map (byte addresses)
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_STRINGS = 8'h0c;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // status bit positions
  localparam int unsigned EV_SUP_OV = 0;
  localparam int unsigned EV_SUP_UV = 1;
  localparam int unsigned EV_SW_OV = 2;
  localparam int unsigned EV_BST_OV = 3;
  localparam int unsigned EV_THERM = 4;
  localparam int unsigned EV_OPEN = 5;
  localparam int unsigned EV_SHORT = 6;
  localparam int unsigned EV_W = 7;
  localparam logic [EV_W-1:0] MASK_RST = 7'h00;
  localparam logic CTRL_MASK_ALL_RST = 1'b0;

  // gray codes along standby, soft, boost, normal, retry
  typedef enum logic [2:0] {
    ST_STANDBY = 3'h0,
    ST_SOFT = 3'h1,
    ST_BOOST = 3'h3,
    ST_NORMAL = 3'h2,
    ST_RETRY = 3'h6
  } blfss_state_type;

  typedef struct packed {
    logic supply_overvoltage;
    logic supply_undervoltage_lockout;
    logic switch_node_overvoltage;
    logic boost_output_overvoltage;
    logic thermal_shutdown;
    logic boost_target_max;
    logic [NUM_STR-1:0] sink_below_low;
    logic [NUM_STR-1:0] sink_in_window;
    logic [NUM_STR-1:0] sink_above_high;
    logic [NUM_STR-1:0] sink_grounded;
  } blfss_flags_type;

  typedef struct packed {
    logic converter_enable;
    logic power_fet_enable;
    logic regulator_enable;
    logic reduced_limit;
    logic fault_n;
    logic [NUM_STR-1:0] sink_enable;
    logic [NUM_STR-1:0] adaptive_include;
  } blfss_drive_type;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } blfss_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } blfss_axi_rsp_type;

endpackage

/* hdl/blfss_top.sv */
// supervisory state machine of a multi-string backlight driver
`timescale 1ns/1ps

module blfss_top
  import blfss_pkg::*;
#(
  parameter int unsigned SOFT_CYC = SOFT_START_CYC,
  parameter int unsigned BOOST_CYC = BOOST_START_CYC,
  parameter int unsigned RETRY_CYCLES = RETRY_CYC,
  parameter int unsigned BOVP_CYC = BOOST_OVP_CYC
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // host pins
  input wire logic i_enable_input,
  input wire logic i_pwm,
  // comparator flags
  input wire blfss_pkg::blfss_flags_type i_flags,
  // power stage drive and interrupt
  output blfss_pkg::blfss_drive_type o_drive,
  output logic o_irq,
  // axi4-lite slave
  input wire blfss_pkg::blfss_axi_req_type i_axi,
  output blfss_pkg::blfss_axi_rsp_type o_axi
);
  import blfss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0] en_sync;
    logic [1:0] pwm_sync;
    blfss_flags_type flg_s1;
    blfss_flags_type flg_s2;
    blfss_state_type state;
    logic [CNT_W-1:0] state_cnt;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] bovp_cnt;
    logic thermal_latched;
    logic from_retry;
    logic [NUM_STR-1:0] used;
    logic [NUM_STR-1:0] str_fault;
    blfss_drive_type drive;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic mask_all;
    logic irq;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    blfss_axi_rsp_type axi;
  } blfss_regs_type;

  blfss_regs_type r_reg;
  blfss_regs_type r_next;

  function automatic logic is_running(input blfss_state_type s);
    is_running = (s == ST_SOFT) || (s == ST_BOOST) || (s == ST_NORMAL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic en_s;
  logic pwm_s;
  logic en_low_long;
  logic supply_fault;
  logic bovp_fault;
  logic retry_fault;
  logic [NUM_STR-1:0] open_det;
  logic [NUM_STR-1:0] short_det;
  logic [EV_W-1:0] events;
  logic [31:0] rd_data;

  always_comb
  begin
    en_s = r_reg.en_sync[1];
    pwm_s = r_reg.pwm_sync[1];
    en_low_long = !en_s && (r_reg.low_cnt >= CNT_W'(EN_STANDBY_CYC));
    supply_fault = is_running(r_reg.state) &&
      (r_reg.flg_s2.supply_overvoltage ||
       r_reg.flg_s2.supply_undervoltage_lockout ||
       r_reg.flg_s2.switch_node_overvoltage);
    bovp_fault = (r_reg.state == ST_NORMAL) &&
      (r_reg.bovp_cnt >= CNT_W'(BOVP_CYC));
    retry_fault = supply_fault || bovp_fault ||
      (is_running(r_reg.state) && r_reg.flg_s2.thermal_shutdown);
    for (int i = 0; i < NUM_STR; i++)
    begin
      open_det[i] = r_reg.flg_s2.boost_target_max &&
        r_reg.flg_s2.sink_below_low[i] && r_reg.used[i];
      short_det[i] = r_reg.flg_s2.sink_above_high[i] && r_reg.used[i] &&
        |(r_reg.flg_s2.sink_in_window & r_reg.used);
    end
    if (r_reg.state != ST_NORMAL)
    begin
      open_det = '0;
      short_det = '0;
    end
    events = '0;
    events[EV_SUP_OV] = is_running(r_reg.state) &&
      r_reg.flg_s2.supply_overvoltage;
    events[EV_SUP_UV] = is_running(r_reg.state) &&
      r_reg.flg_s2.supply_undervoltage_lockout;
    events[EV_SW_OV] = is_running(r_reg.state) &&
      r_reg.flg_s2.switch_node_overvoltage;
    events[EV_BST_OV] = bovp_fault;
    events[EV_THERM] = is_running(r_reg.state) &&
      r_reg.flg_s2.thermal_shutdown;
    events[EV_OPEN] = |open_det;
    events[EV_SHORT] = |short_det;
    unique case (i_axi.araddr)
      ADDR_STATUS: rd_data = 32'(r_reg.status);
      ADDR_MASK: rd_data = 32'(r_reg.mask);
      ADDR_STATE: rd_data = 32'({r_reg.thermal_latched, r_reg.state});
      ADDR_STRINGS: rd_data = 32'({r_reg.str_fault, r_reg.used});
      ADDR_CTRL: rd_data = 32'(r_reg.mask_all);
      default: rd_data = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    r_next = r_reg;
    // two-stage synchronisers; first stage read only by the second
    r_next.en_sync = {r_reg.en_sync[0], i_enable_input};
    r_next.pwm_sync = {r_reg.pwm_sync[0], i_pwm};
    r_next.flg_s1 = i_flags;
    r_next.flg_s2 = r_reg.flg_s1;
    r_next.state_cnt = r_reg.state_cnt + CNT_W'(1);
    r_next.low_cnt = en_s ? '0 : r_reg.low_cnt + CNT_W'(1);
    if (r_reg.low_cnt == '1)
      r_next.low_cnt = r_reg.low_cnt;
    r_next.bovp_cnt = (r_reg.state == ST_NORMAL &&
      r_reg.flg_s2.boost_output_overvoltage) ?
      r_reg.bovp_cnt + CNT_W'(1) : '0;
    if (!r_reg.flg_s2.thermal_shutdown)
      r_next.thermal_latched = 1'b0;
    r_next.str_fault = r_reg.str_fault | open_det | short_det;
    r_next.used = r_reg.used & ~(open_det | short_det);

    unique case (r_reg.state)
      ST_STANDBY:
      begin
        if (en_s)
        begin
          r_next.state = ST_SOFT;
          r_next.state_cnt = '0;
          r_next.used = '1;
        end
      end
      ST_SOFT:
      begin
        if (r_reg.state_cnt >= CNT_W'(SOFT_CYC) - CNT_W'(1))
        begin
          r_next.state = ST_BOOST;
          r_next.state_cnt = '0;
        end
      end
      ST_BOOST:
      begin
        if (r_reg.state_cnt >= CNT_W'(BOOST_CYC) - CNT_W'(1))
        begin
          r_next.used = r_reg.used & ~r_reg.flg_s2.sink_grounded;
          r_next.state = r_reg.thermal_latched ? ST_RETRY : ST_NORMAL;
          r_next.state_cnt = '0;
        end
      end
      ST_NORMAL:
      begin
        // a 2 to 20 us low pulse clears latched string faults
        if (!en_s &&
            r_reg.low_cnt >= CNT_W'(EN_CLEAR_MIN_CYC) - CNT_W'(1) &&
            r_reg.low_cnt < CNT_W'(EN_CLEAR_MAX_CYC))
          r_next.str_fault = '0;
      end
      ST_RETRY:
      begin
        if (r_reg.state_cnt >= CNT_W'(RETRY_CYCLES) - CNT_W'(1))
        begin
          r_next.state = en_s ? ST_SOFT : ST_STANDBY;
          r_next.state_cnt = '0;
          r_next.used = '1;
        end
      end
    endcase
    if (retry_fault)
    begin
      r_next.state = ST_RETRY;
      r_next.state_cnt = '0;
      r_next.from_retry = 1'b1;
      if (r_reg.flg_s2.thermal_shutdown)
        r_next.thermal_latched = 1'b1;
    end
    if (en_low_long)
    begin
      r_next.state = ST_STANDBY;
      r_next.state_cnt = '0;
      r_next.from_retry = 1'b0;
      r_next.str_fault = '0;
    end

    // outputs from the next state, so they are registered
    r_next.drive.regulator_enable = r_next.state != ST_STANDBY;
    r_next.drive.power_fet_enable = is_running(r_next.state);
    r_next.drive.converter_enable = (r_next.state == ST_BOOST) ||
      (r_next.state == ST_NORMAL);
    r_next.drive.reduced_limit = r_next.state == ST_BOOST;
    r_next.drive.adaptive_include = r_next.state == ST_NORMAL ?
      r_next.used : '0;
    // strings dark while enable is low, even in a short clearing pulse
    r_next.drive.sink_enable = (r_next.state == ST_NORMAL && pwm_s && en_s) ?
      r_next.used : '0;
    if (r_next.state == ST_RETRY)
      r_next.drive.fault_n = 1'b0;
    else if (r_next.state == ST_NORMAL && r_reg.state != ST_NORMAL &&
             !retry_fault)
    begin
      r_next.drive.fault_n = 1'b1;
      r_next.from_retry = 1'b0;
    end
    else if (r_next.state == ST_NORMAL)
      r_next.drive.fault_n = ~|r_next.str_fault;
    else if (r_next.state == ST_STANDBY)
      r_next.drive.fault_n = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // interrupt status: set wins over write-one-to-clear
    r_next.irq = 1'b0;
    if (r_reg.axi.bvalid && i_axi.bready)
      r_next.axi.bvalid = 1'b0;
    if (r_reg.axi.rvalid && i_axi.rready)
      r_next.axi.rvalid = 1'b0;
    if (r_reg.axi.awready && i_axi.awvalid)
    begin
      r_next.aw_got = 1'b1;
      r_next.aw_addr = i_axi.awaddr;
    end
    if (r_reg.axi.wready && i_axi.wvalid)
    begin
      r_next.w_got = 1'b1;
      r_next.w_data = i_axi.wdata;
      if (!i_axi.wstrb[0])
        r_next.w_data[7:0] = 8'h00;
    end
    r_next.axi.awready = !r_next.aw_got && !r_next.axi.bvalid;
    r_next.axi.wready = !r_next.w_got && !r_next.axi.bvalid;
    if (r_reg.aw_got && r_reg.w_got && !r_reg.axi.bvalid)
    begin
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.axi.bvalid = 1'b1;
      r_next.axi.bresp = RESP_OKAY;
      unique case (r_reg.aw_addr)
        ADDR_STATUS: r_next.status = r_reg.status & ~r_reg.w_data[EV_W-1:0];
        ADDR_MASK: r_next.mask = r_reg.w_data[EV_W-1:0];
        ADDR_CTRL: r_next.mask_all = r_reg.w_data[0];
        ADDR_STATE, ADDR_STRINGS: r_next.axi.bresp = RESP_OKAY;
        default: r_next.axi.bresp = RESP_SLVERR;
      endcase
    end
    r_next.status = r_next.status | events;
    r_next.irq = !r_reg.mask_all && |(r_reg.status & r_reg.mask);
    if (r_reg.axi.arready && i_axi.arvalid)
    begin
      r_next.axi.arready = 1'b0;
      r_next.axi.rvalid = 1'b1;
      r_next.axi.rdata = rd_data;
      r_next.axi.rresp = (i_axi.araddr <= ADDR_CTRL &&
        i_axi.araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (!r_next.axi.rvalid)
      r_next.axi.arready = 1'b1;

    if (!i_rst_n)
    begin
      r_next = '0;
      r_next.state = ST_STANDBY;
      r_next.drive.fault_n = 1'b1;
      r_next.mask = MASK_RST;
      r_next.mask_all = CTRL_MASK_ALL_RST;
    end
  end

  always_ff @(posedge i_clk)
  begin
    r_reg <= r_next;
  end

  always_comb
  begin
    o_drive = r_reg.drive;
    o_irq = r_reg.irq;
    o_axi = r_reg.axi;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_retry_drive_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    r_reg.state == ST_RETRY |-> !o_drive.converter_enable &&
    o_drive.sink_enable == '0 && !o_drive.fault_n)
    else $error("retry state with drive active");
  a_thermal_to_retry: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    is_running(r_reg.state) && r_reg.flg_s2.thermal_shutdown && !en_low_long
    |=> r_reg.state == ST_RETRY && !o_drive.power_fet_enable)
    else $error("thermal flag did not force retry");
  a_no_normal_hot: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    r_reg.state == ST_BOOST && r_reg.thermal_latched |=>
    r_reg.state != ST_NORMAL)
    else $error("normal entered with thermal latched");
  a_supply_retry: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    supply_fault && !en_low_long |=> r_reg.state == ST_RETRY)
    else $error("supply fault missed");
  a_idle_ignores: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    r_reg.state == ST_STANDBY && !en_s |=> r_reg.state == ST_STANDBY)
    else $error("standby left without enable");
  a_wake_soft: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    r_reg.state == ST_STANDBY && en_s |=> r_reg.state == ST_SOFT
    && o_drive.regulator_enable)
    else $error("enable did not wake device");
  a_sinks_pwm: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_drive.sink_enable != '0 |-> r_reg.state == ST_NORMAL &&
    $past(pwm_s) && (o_drive.sink_enable & ~r_reg.used) == '0)
    else $error("sink enabled outside normal pwm");
  a_long_low_stby: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    en_low_long |=> r_reg.state == ST_STANDBY)
    else $error("long enable low did not reach standby");
  a_bovp_filter: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    r_reg.state == ST_NORMAL && !supply_fault && !en_low_long &&
    !r_reg.flg_s2.thermal_shutdown && r_reg.bovp_cnt < CNT_W'(BOVP_CYC)
    |=> r_reg.state == ST_NORMAL)
    else $error("boost overvoltage acted too early");
  a_open_drop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (|open_det) && !retry_fault && !en_low_long |=> r_reg.state == ST_NORMAL
    && (r_reg.used & $past(open_det)) == '0)
    else $error("open string not dropped");
  a_retry_length: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    r_reg.state == ST_RETRY && !en_low_long &&
    r_reg.state_cnt < CNT_W'(RETRY_CYCLES) - CNT_W'(1)
    |=> r_reg.state == ST_RETRY)
    else $error("retry state left early");
  a_retry_exit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    r_reg.state == ST_RETRY && en_s &&
    r_reg.state_cnt == CNT_W'(RETRY_CYCLES) - CNT_W'(1)
    |=> r_reg.state == ST_SOFT)
    else $error("retry did not restart soft start");
  a_retry_release: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (r_reg.state == ST_BOOST && r_reg.from_retry) ##1
    (r_reg.state == ST_NORMAL) |-> o_drive.fault_n)
    else $error("fault output held after recovery");
  a_string_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    r_reg.state == ST_NORMAL && !en_s && !retry_fault &&
    r_reg.low_cnt == CNT_W'(EN_CLEAR_MIN_CYC) - CNT_W'(1)
    |=> r_reg.str_fault == '0 && o_drive.fault_n)
    else $error("short enable pulse did not clear string faults");
  a_pulse_dark: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !en_s |=> o_drive.sink_enable == '0)
    else $error("strings lit while enable low");

endmodule

/* test/blfss_host_model.sv */
// host model: drives the enable and pwm pins of the sequencer
`timescale 1ns/1ps
module blfss_host_model
(
  // clock
  input wire logic i_clk,
  // commands from the bench
  input wire logic i_en_cmd,
  input wire logic i_pwm_cmd,
  input wire logic i_low_go,
  input wire logic [15:0] i_low_cycles,
  // host pins
  output logic o_enable_input,
  output logic o_pwm
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] low_cnt_reg = 16'h0000;

  // timed low pulse; length decides string clear or standby
  always @(posedge i_clk)
  begin
    if (i_low_go)
      low_cnt_reg <= i_low_cycles;
    else if (low_cnt_reg != 16'h0000)
      low_cnt_reg <= low_cnt_reg - 16'h0001;
  end

  // pins follow the bench commands combinationally; only the low pulse counter is clocked
  assign o_enable_input = i_en_cmd && (low_cnt_reg == 16'h0000);
  assign o_pwm = i_pwm_cmd;
endmodule

/* test/tb_top.sv */
// self-checking bench of the backlight fault sequencer
`timescale 1ns/1ps
module tb_top;
  import blfss_pkg::*;
  // short counts so the run stays brief
  localparam int unsigned SOFT = 200;
  localparam int unsigned BOOST = 150;
  localparam int unsigned RETRY = 300;
  localparam int unsigned BOVP = 400;
  localparam int LIMIT = 40000;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic en_cmd = 1'b0;
  logic pwm_cmd = 1'b0;
  logic low_go = 1'b0;
  logic [15:0] low_len = 16'h0000;
  logic enable_pin;
  logic pwm_pin;
  logic irq;
  blfss_flags_type flags = '0;
  blfss_drive_type drive;
  blfss_axi_req_type req = '0;
  blfss_axi_rsp_type rsp;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int n;
  int seen;
  logic [31:0] rd;
  logic [1:0] resp;
  ////////////////////////////////////////////////////////////////////////////
  always #2.5 i_clk = ~i_clk;

  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      fails = fails + 1;
      stop_test();
    end
  end

  blfss_host_model host (.i_clk(i_clk), .i_en_cmd(en_cmd),
    .i_pwm_cmd(pwm_cmd), .i_low_go(low_go), .i_low_cycles(low_len),
    .o_enable_input(enable_pin), .o_pwm(pwm_pin));

  blfss_top #(.SOFT_CYC(SOFT), .BOOST_CYC(BOOST), .RETRY_CYCLES(RETRY),
    .BOVP_CYC(BOVP)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_enable_input(enable_pin), .i_pwm(pwm_pin), .i_flags(flags),
    .o_drive(drive), .o_irq(irq), .i_axi(req), .o_axi(rsp));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge i_clk);
  endtask

  // outputs are registered, so values read after the edge are pre-edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    forever
    begin
      @(posedge i_clk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (req.bready && rsp.bvalid)
      begin
        resp = rsp.bresp;
        req.bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge i_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    forever
    begin
      @(posedge i_clk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (req.rready && rsp.rvalid)
      begin
        rd = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        break;
      end
    end
  endtask

  // polls the state register; n gets the cycles spent waiting
  task automatic wait_state(input blfss_state_type s, input int max);
    int t0;
    t0 = cyc;
    do
      axi_rd(ADDR_STATE);
    while (rd[2:0] !== s && cyc - t0 < max);
    n = cyc - t0;
    check({29'h0, rd[2:0]}, {29'h0, s});
  endtask

  task automatic pulse_low(input logic [15:0] k);
    @(posedge i_clk);
    low_len <= k;
    low_go <= 1'b1;
    @(posedge i_clk);
    low_go <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    wait_cyc(2);
    check({19'h0, drive}, 32'h0000_0100);
    axi_rd(ADDR_STATE);
    check(rd, 32'h0);
    axi_rd(ADDR_MASK);
    check(rd, 32'h0);
    axi_rd(8'h40);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_wr(8'h40, 32'h0);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    flags.thermal_shutdown <= 1'b1;
    wait_cyc(20);
    axi_rd(ADDR_STATE);
    check(rd[2:0], ST_STANDBY);
    flags <= '0;
    wait_cyc(10);
    en_cmd <= 1'b1;
    wait_state(ST_SOFT, 40);
    check(drive.regulator_enable, 1'b1);
    wait_state(ST_BOOST, SOFT + 40);
    check(n > SOFT - 20, 1'b1);
    flags.sink_grounded <= 4'h8;
    check(drive.converter_enable & drive.reduced_limit, 1'b1);
    wait_state(ST_NORMAL, BOOST + 40);
    check(n > BOOST - 20, 1'b1);
    check(drive.adaptive_include, 4'h7);
    flags <= '0;
    pwm_cmd <= 1'b1;
    wait_cyc(10);
    check(drive.sink_enable, 4'h7);
    pwm_cmd <= 1'b0;
    wait_cyc(10);
    check(drive.sink_enable, 4'h0);
    pwm_cmd <= 1'b1;
    // open string, then the interrupt raised, unmasked and cleared
    flags.boost_target_max <= 1'b1;
    flags.sink_below_low <= 4'h1;
    wait_cyc(10);
    check(drive.fault_n, 1'b0);
    check(drive.sink_enable, 4'h6);
    check(irq, 1'b0);
    axi_wr(ADDR_MASK, 32'h20);
    check({30'h0, resp}, {30'h0, RESP_OKAY});
    wait_cyc(3);
    check(irq, 1'b1);
    axi_wr(ADDR_CTRL, 32'h1);
    wait_cyc(3);
    check(irq, 1'b0);
    axi_wr(ADDR_CTRL, 32'h0);
    flags <= '0;
    wait_cyc(6);
    axi_wr(ADDR_STATUS, 32'h20);
    wait_cyc(3);
    check(irq, 1'b0);
    axi_rd(ADDR_STATUS);
    check(rd, 32'h0);
    axi_rd(ADDR_STATE);
    check(rd[2:0], ST_NORMAL);
    flags.sink_above_high <= 4'h2;
    flags.sink_in_window <= 4'h4;
    wait_cyc(10);
    check(drive.fault_n, 1'b0);
    check(drive.sink_enable[1], 1'b0);
    axi_rd(ADDR_STRINGS);
    check(rd, 32'h34);
    flags <= '0;
    // 5 us low pulse clears the latched string faults
    pulse_low(16'h03e8);
    wait_cyc(500);
    check(drive.sink_enable, 4'h0);
    wait_cyc(600);
    check(drive.fault_n, 1'b1);
    check(drive.sink_enable, 4'h4);
    axi_rd(ADDR_STATE);
    check(rd[2:0], ST_NORMAL);
    axi_rd(ADDR_STRINGS);
    check(rd, 32'h04);
    flags.boost_output_overvoltage <= 1'b1;
    wait_cyc(BOVP - 100);
    flags <= '0;
    wait_cyc(10);
    axi_rd(ADDR_STATE);
    check(rd[2:0], ST_NORMAL);
    flags.boost_output_overvoltage <= 1'b1;
    wait_cyc(BOVP - 100);
    axi_rd(ADDR_STATE);
    check(rd[2:0], ST_NORMAL);
    wait_state(ST_RETRY, 200);
    check({drive.converter_enable, drive.sink_enable, drive.fault_n}, 0);
    flags <= '0;
    wait_state(ST_SOFT, RETRY + 40);
    check(n > RETRY - 20, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      flags.supply_overvoltage <= (i == 0);
      flags.supply_undervoltage_lockout <= (i == 1);
      flags.switch_node_overvoltage <= (i == 2);
      wait_state(ST_RETRY, 30);
      check(drive.converter_enable, 1'b0);
      axi_rd(ADDR_STATUS);
      check(rd[i], 1'b1);
      flags <= '0;
      wait_state(ST_SOFT, RETRY + 40);
    end
    wait_state(ST_NORMAL, SOFT + BOOST + 80);
    check(drive.fault_n, 1'b1);
    flags.thermal_shutdown <= 1'b1;
    wait_cyc(10);
    check({drive.converter_enable, drive.power_fet_enable,
      drive.fault_n, drive.sink_enable}, 0);
    wait_state(ST_RETRY, 20);
    seen = 0;
    repeat (60)
    begin
      axi_rd(ADDR_STATE);
      if (rd[2:0] === ST_NORMAL)
        seen++;
      wait_cyc(30);
    end
    check(seen, 0);
    flags <= '0;
    wait_state(ST_NORMAL, 2000);
    check(drive.fault_n, 1'b1);
    // held low past 50 us: the only way back to standby outside retry
    en_cmd <= 1'b0;
    wait_cyc(9000);
    axi_rd(ADDR_STATE);
    check(rd[2:0], ST_NORMAL);
    wait_state(ST_STANDBY, 1200);
    en_cmd <= 1'b1;
    wait_state(ST_SOFT, 40);
    stop_test();
  end
endmodule
